// [dbac_attr_ctrl.sv]
// control word and bus attribute logic of a debug memory access port
`include "dbac_defs.svh"
module dbac_attr_ctrl
   import dbac_pkg::*;
#(
   parameter dbac_bus_t BUS = DBAC_AHB,
   parameter bit HAS_MSEL = 1'b1,
   parameter bit HAS_ALLOC = 1'b1,
   parameter bit HAS_NONSEC = 1'b1,
   parameter bit HAS_SECDBG = 1'b1,
   parameter bit HAS_TGT_IN = 1'b1,
   parameter bit HAS_PACKED = 1'b0,
   parameter logic [3:0] OWN_ID = 4'h1,
   parameter logic [3:0] ALT_ID = 4'h2
) (
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic o_hreadyout,
   output logic o_hresp,
   output logic [31:0] o_hrdata,
   input wire logic i_secure_debug_permit,
   input wire logic i_target_enable_input,
   input wire logic i_dw_req,
   input wire logic i_mem_done,
   input wire logic i_abort,
   output logic o_mem_go,
   output logic o_dw_err,
   output logic o_transfer_in_flight,
   output logic [6:0] o_hprot,
   output logic [3:0] o_hmaster,
   output logic o_hnonsec,
   output logic [2:0] o_pprot,
   output logic [2:0] o_size,
   output logic [1:0] o_address_increment_mode
);

   // what the block does, variant by variant
   // one control word, reached at the first word of the register bus
   // the word sets the attributes of every transfer sent to memory
   // bits 30:24 hold protection attributes, their use depends on the bus
   // bit 23 is the secure-debug permit, read only
   // bit 7 is the in-flight flag, read only
   // bit 6 is the target-enable mirror, read only
   // bits 5:4 select the address increment mode
   // bits 2:0 select the access size
   // all other bits read zero and drop writes
   // older system bus:
   //    bit 30 stored as written, software keeps it one
   //    bit 29 picks own or second master id, if built
   //    bit 28 drives the allocate hint, if built
   //    bits 27:24 drive the low protection bits directly
   //    sizes byte, halfword and word accepted
   // newer system bus:
   //    bit 30 drives the non-secure line, if built, reset one
   //    bit 29 as above, reads zero when not built
   //    bit 28 reads zero
   //    bit 27 fans out to three protection bits
   //    protection bit 5 tied low
   // legacy peripheral bus:
   //    all protection bits read zero
   //    size fixed at word, increment reads zero
   // newer peripheral bus:
   //    bits 30:28 drive the peripheral protection lines
   //    a secure request without permit is refused
   //    size fixed at word, increment reads zero
   // transfer handshake:
   //    a request is issued or refused one cycle later
   //    issue needs an enabled target and an idle link
   //    in-flight holds until memory reports completion
   //    an abort leaves in-flight alone, software polls it
   // hazards:
   //    a write to the word lands one cycle after its address phase
   //    a read in that same cycle sees the new value
   //    attribute outputs follow the word one cycle later

   // refuse builds the logic cannot serve
   if (HAS_PACKED && (BUS == DBAC_APB23 || BUS == DBAC_APB4)) begin : g_chk
      $error("packed increment not available on APB variants");
   end

   localparam bit IS_AHB = (BUS == DBAC_AHB);
   localparam bit IS_AHB5 = (BUS == DBAC_AHB5);
   localparam bit IS_APB4 = (BUS == DBAC_APB4);
   localparam bit ANY_AHB = IS_AHB || IS_AHB5;

   // writable bits per variant; everything else reads as built
   // reserved bits
   localparam logic [31:0] WMASK =
      IS_AHB ? ({1'b0, 1'b1, HAS_MSEL, HAS_ALLOC, 4'hf, 24'h0}
                | 32'h0000_0037) :
      IS_AHB5 ? ({1'b0, HAS_NONSEC, HAS_MSEL, 1'b0, 4'hf, 24'h0}
                 | 32'h0000_0037) :
      IS_APB4 ? 32'h7000_0000 : 32'h0000_0000;
   localparam logic [31:0] RSTVAL =
      IS_AHB ? `DBAC_RST_AHB :
      IS_AHB5 ? (HAS_NONSEC ? `DBAC_RST_AHB5 : `DBAC_RST_APB) :
      `DBAC_RST_APB;

   logic [31:0] ctl_q;
   logic [31:0] ctl_d;
   logic wr_pend_q;
   logic rd_sel_q;
   logic infl_q;
   logic infl_d;

   // address phase qualification
   wire addr_ok = i_hsel && i_htrans[1] && i_hready;
   wire hit = (i_haddr[11:0] == `DBAC_OFS_CTL);
   wire wr_take = addr_ok && i_hwrite && hit;
   wire rd_take = addr_ok && !i_hwrite && hit;

   // field legality of the write data
   // byte, halfword, word sizes
   wire size_ok = ANY_AHB && (i_hwdata[2:0] <= `DBAC_SIZE_WORD);
   wire inc_ok = HAS_PACKED || (i_hwdata[5:4] != `DBAC_INC_PACKED);
   wire [31:0] fld_mask = WMASK
      & ~{26'h0, !inc_ok, !inc_ok, 1'b0, !size_ok, !size_ok, !size_ok};
   assign ctl_d = wr_pend_q ? ((ctl_q & ~fld_mask) | (i_hwdata & fld_mask))
                            : ctl_q;

   // stored fields of the control word
   wire [2:0] prot_hi = ctl_q[30:28]; // non-secure, select, allocate
   wire [3:0] prot_lo = ctl_q[27:24]; // low protection bits
   wire [2:0] size_fld = ctl_q[2:0]; // access size
   wire [1:0] inc_fld = ctl_q[5:4]; // increment mode

   // permit bit read-only, zero without secure debug
   wire permit = HAS_SECDBG && (BUS != DBAC_APB23)
                 && i_secure_debug_permit;
   // target enable mirrors input, one if absent
   wire tgt_en = HAS_TGT_IN ? i_target_enable_input : 1'b1;

   // secure request without permit is refused
   wire sec_block = IS_APB4 && !prot_hi[1] && !permit;
   wire can_go = tgt_en && !sec_block && !infl_q;
   wire go_d = i_dw_req && can_go;
   wire err_d = i_dw_req && !can_go;

   // in-flight held until completion, abort does not clear
   assign infl_d = go_d || (infl_q && !i_mem_done);

   // read image, using any write landing this cycle
   // increment reads zero on APB
   wire [31:0] rd_img = {1'b0, ctl_d[30:24], permit, 15'h0, infl_q, tgt_en,
                         ctl_d[5:4], 1'b0,
                         ANY_AHB ? ctl_d[2:0] : `DBAC_SIZE_WORD};

   wire [6:0] hprot_ahb = {2'h0, ctl_q[`DBAC_B_ALLOC], prot_lo};

   // per-bit fan-out of the newer system bus protection
   // bit 27 to 6, 4, 3; bit 5 low
   logic [6:0] hprot_ahb5;
   for (genvar b = 0; b < 7; b++) begin : g_hprot5
      if (b == 5) begin : g_low
         assign hprot_ahb5[b] = 1'b0;
      end else if (b == 6 || b == 4 || b == 3) begin : g_fan
         assign hprot_ahb5[b] = prot_lo[3];
      end else begin : g_direct
         assign hprot_ahb5[b] = prot_lo[b];
      end
   end

   wire [6:0] hprot_d = IS_AHB ? hprot_ahb :
                        IS_AHB5 ? hprot_ahb5 : 7'h00;
   wire [3:0] hmaster_d = (HAS_MSEL && !ctl_q[`DBAC_B_MSEL]) ? ALT_ID
                                                             : OWN_ID;
   // bit 30 kept as written; zero is the software's fault
   wire nonsec_d = IS_AHB5 && ctl_q[`DBAC_B_NONSEC];
   wire [2:0] pprot_d = IS_APB4 ? prot_hi : 3'h0;
   // size fixed at word on peripheral buses
   wire [2:0] size_d = ANY_AHB ? size_fld : `DBAC_SIZE_WORD;
   // read data only in the data phase of a hit
   wire [31:0] hrdata_d = rd_take ? rd_img : 32'h0;

   // control word register
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         ctl_q <= RSTVAL;
      end else begin
         ctl_q <= ctl_d;
      end
   end

   // write data phase pending
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         wr_pend_q <= 1'b0;
      end else begin
         wr_pend_q <= wr_take;
      end
   end

   // read data phase pending
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         rd_sel_q <= 1'b0;
      end else begin
         rd_sel_q <= rd_take;
      end
   end

   // in-flight state, set wins over completion
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         infl_q <= 1'b0;
      end else begin
         infl_q <= infl_d;
      end
   end

   // bus answer: zero wait
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hreadyout <= 1'b1;
      end else begin
         o_hreadyout <= 1'b1;
      end
   end

   // bus answer: always okay
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hresp <= 1'b0;
      end else begin
         o_hresp <= 1'b0;
      end
   end

   // read data register
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hrdata <= 32'h0;
      end else begin
         o_hrdata <= hrdata_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_mem_go <= 1'b0;
      end else begin
         o_mem_go <= go_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_dw_err <= 1'b0;
      end else begin
         o_dw_err <= err_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_transfer_in_flight <= 1'b0;
      end else begin
         o_transfer_in_flight <= infl_d;
      end
   end

   // protection attributes of the system bus
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hprot <= 7'h00;
      end else begin
         o_hprot <= hprot_d;
      end
   end

   // master identity
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hmaster <= 4'h0;
      end else begin
         o_hmaster <= hmaster_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_hnonsec <= 1'b0;
      end else begin
         o_hnonsec <= nonsec_d;
      end
   end

   // peripheral protection lines
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_pprot <= 3'h0;
      end else begin
         o_pprot <= pprot_d;
      end
   end

   // access size
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_size <= `DBAC_SIZE_WORD;
      end else begin
         o_size <= size_d;
      end
   end

   // increment mode, zero on peripheral buses by mask
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) begin
         o_address_increment_mode <= 2'h0;
      end else begin
         o_address_increment_mode <= inc_fld;
      end
   end

   // abort is accepted but leaves the in-flight state to the bus
   wire unused_ok = &{1'b0, i_abort, i_hsize, i_haddr[31:12], rd_sel_q};

endmodule : dbac_attr_ctrl

// [dbac_defs.svh]
// constants for the debug bus attribute control block
`ifndef DBAC_DEFS_SVH
`define DBAC_DEFS_SVH
`define DBAC_OFS_CTL 12'h000
`define DBAC_B_NONSEC 30
`define DBAC_B_MSEL 29
`define DBAC_B_ALLOC 28
`define DBAC_B_PERMIT 23
`define DBAC_B_INFL 7
`define DBAC_B_TGTEN 6
`define DBAC_RST_AHB 32'h4300_0002
`define DBAC_RST_AHB5 32'h4000_0002
`define DBAC_RST_APB 32'h0000_0002
`define DBAC_SIZE_WORD 3'h2
`define DBAC_INC_PACKED 2'h2
`endif

// [dbac_pkg.sv]
// types for the debug bus attribute control block
package dbac_pkg;
   typedef enum logic [1:0] {
      DBAC_AHB = 2'b00,
      DBAC_AHB5 = 2'b01,
      DBAC_APB23 = 2'b10,
      DBAC_APB4 = 2'b11
   } dbac_bus_t;
endpackage : dbac_pkg

// [dbac_checker.sv]
// port checker for the attribute control block
module dbac_checker #(
   parameter logic [3:0] OWN_ID = 4'h1,
   parameter logic [3:0] ALT_ID = 4'h2
) (
   input wire logic i_clk_sys, i_rstn, i_hsel, i_hwrite, i_hready,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_dw_req, i_mem_done, i_target_enable_input,
   input wire logic o_hreadyout, o_hresp, o_mem_go, o_dw_err,
   input wire logic o_transfer_in_flight,
   input wire logic [31:0] o_hrdata,
   input wire logic [6:0] o_hprot,
   input wire logic [3:0] o_hmaster
);
   logic rd_q, wr_q;
   wire logic take = i_rstn & i_hsel & i_htrans[1] & i_hready;
   // data phase trackers: reads of the control word, writes to any address
   always_ff @(posedge i_clk_sys) begin
      rd_q <= take & !i_hwrite & (i_haddr[11:0] == 12'h000);
      wr_q <= take & i_hwrite;
   end
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);
   sequence ctl_rd;
      rd_q && !$past(wr_q);
   endsequence
   bus_okay_a: assert property (o_hreadyout && !o_hresp)
      else $error("bus answer not okay");
   answer_one_a: assert property (i_dw_req |=> o_mem_go != o_dw_err)
      else $error("request answer count wrong");
   go_flight_a: assert property (o_mem_go |-> o_transfer_in_flight)
      else $error("issued transfer not in flight");
   off_refuse_a: assert property (i_dw_req && !i_target_enable_input &&
      !$past(i_target_enable_input) |=> o_dw_err)
      else $error("disabled target not refused");
   busy_refuse_a: assert property (i_dw_req && o_transfer_in_flight
      |=> o_dw_err)
      else $error("busy request not refused");
   done_clear_a: assert property (i_mem_done && !i_dw_req && !o_mem_go
      |=> !o_transfer_in_flight)
      else $error("in flight not cleared");
   prot_drive_a: assert property (ctl_rd |->
      o_hrdata[28:24] == o_hprot[4:0])
      else $error("protection outputs differ");
   msel_id_a: assert property (ctl_rd |->
      o_hmaster == (o_hrdata[29] ? OWN_ID : ALT_ID))
      else $error("master id wrong");
   res_zero_a: assert property (rd_q |-> o_hrdata[22:8] == 15'h0 &&
      !o_hrdata[3])
      else $error("reserved bits set");
endmodule : dbac_checker
bind dbac_attr_ctrl dbac_checker #(.OWN_ID(OWN_ID), .ALT_ID(ALT_ID))
   dbac_checker_inst (.*);

// [dbac_mem_model.sv]
// memory side model answering issued transfers
module dbac_mem_model (
   input wire logic i_clk_sys, i_rstn, i_go, i_slow,
   output logic o_done
);
   logic [3:0] cnt_q;
   // done pulse only for an issued transfer
   always_ff @(posedge i_clk_sys) begin
      if (!i_rstn) cnt_q <= 4'h0;
      else if (i_go) cnt_q <= i_slow ? 4'hc : 4'h2;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      o_done <= i_rstn && cnt_q == 4'h1;
   end
endmodule : dbac_mem_model

// [tb_top.sv]
// self-checking bench for the attribute control block
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys = 0, i_rstn = 0, i_hsel = 0, i_hwrite = 0, i_abort = 0;
   logic i_secure_debug_permit = 1, i_target_enable_input = 1;
   logic i_dw_req = 0, slow = 0;
   logic [31:0] i_haddr = 0, i_hwdata = 0, rd;
   logic [1:0] i_htrans = 0;
   logic [2:0] i_hsize = 3'h2;
   wire logic i_hready, o_hreadyout, o_hresp, o_mem_go, o_dw_err;
   wire logic i_mem_done, o_transfer_in_flight, o_hnonsec;
   wire logic [31:0] o_hrdata;
   wire logic [6:0] o_hprot;
   wire logic [3:0] o_hmaster;
   wire logic [2:0] o_pprot, o_size;
   wire logic [1:0] o_address_increment_mode;
   int fail_count = 0, check_count = 0;
   // write, readback, hprot[4:0], master id; bit 30 kept one
   logic [31:0] rows[4][4] = '{'{32'h5f00_0010, 32'h5f80_0050, 32'h1f, 32'h2},
      '{32'h6100_0011, 32'h6180_0051, 32'h01, 32'h1},
      '{32'h4800_0006, 32'h4880_0041, 32'h08, 32'h2},
      '{32'h5000_0020, 32'h5080_0040, 32'h10, 32'h2}};
   assign i_hready = o_hreadyout;
   dbac_attr_ctrl dbac_attr_ctrl_inst (.*);
   dbac_mem_model dbac_mem_model_inst (.i_clk_sys, .i_rstn, .i_go(o_mem_go),
      .i_slow(slow), .o_done(i_mem_done));
   // bench clock
   initial forever #25 i_clk_sys = ~i_clk_sys;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e) begin
         fail_count++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [31:0] a, d);
      i_hsel <= 1'b1; i_haddr <= a; i_htrans <= 2'h2; i_hwrite <= w;
      do @(posedge i_clk_sys); while (i_hready !== 1'b1);
      i_hsel <= 1'b0; i_htrans <= 2'h0; i_hwdata <= d;
      do @(posedge i_clk_sys); while (i_hready !== 1'b1);
      rd = o_hrdata;
   endtask : bus
   task automatic xfer(input logic [1:0] e);
      i_dw_req <= 1'b1;
      @(posedge i_clk_sys);
      i_dw_req <= 1'b0;
      @(posedge i_clk_sys);
      chk(32'({o_mem_go, o_dw_err}), 32'(e));
   endtask : xfer
   task automatic settle();
      for (int k = 0; k < 40 && o_transfer_in_flight; k++) @(posedge i_clk_sys);
      chk(32'(o_transfer_in_flight), 32'h0);
   endtask : settle
   task automatic final_report();
      $display("checks %0d fails %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : final_report
   // watchdog against a hung handshake
   initial begin
      #100us;
      fail_count++;
      final_report();
   end
   // main sequence
   initial begin
      repeat (20) @(posedge i_clk_sys);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      foreach (rows[i]) begin
         bus(1'b1, 32'h0, rows[i][0]);
         bus(1'b0, 32'h0, 32'h0);
         chk(rd, rows[i][1]);
         chk(32'(o_hprot[4:0]), rows[i][2]);
         chk(32'(o_hmaster), rows[i][3]);
         chk(32'({o_address_increment_mode, 1'b0, o_size}), 32'(rows[i][1][5:0]));
         $display("row %0d done", i);
      end
      i_rstn <= 1'b0;
      repeat (2) @(posedge i_clk_sys);
      chk(32'(o_hprot), 32'h0);
      i_rstn <= 1'b1;
      @(posedge i_clk_sys);
      bus(1'b0, 32'h0, 32'h0);
      chk(rd, 32'h4380_0042);
      chk(32'(o_hprot), 32'h03);
      chk(32'({o_hnonsec, o_pprot, o_hprot[6:5]}), 32'h0);
      bus(1'b1, 32'h4, 32'hffff_ffff);
      bus(1'b0, 32'h4, 32'h0);
      chk(rd, 32'h0);
      i_secure_debug_permit <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      chk(32'(rd[23]), 32'h0);
      $display("reset and map done");
      slow <= 1'b1;
      xfer(2'b10);
      bus(1'b0, 32'h0, 32'h0);
      chk(32'(rd[7]), 32'h1);
      xfer(2'b01);
      i_abort <= 1'b1;
      @(posedge i_clk_sys);
      i_abort <= 1'b0;
      @(posedge i_clk_sys);
      chk(32'(o_transfer_in_flight), 32'h1);
      settle();
      i_target_enable_input <= 1'b0;
      bus(1'b0, 32'h0, 32'h0);
      chk(32'(rd[6]), 32'h0);
      xfer(2'b01);
      i_target_enable_input <= 1'b1;
      slow <= 1'b0;
      @(posedge i_clk_sys);
      xfer(2'b10);
      settle();
      $display("transfers done");
      final_report();
   end
endmodule : tb_top
